/* dpglu_pkg.sv */
// Constants, field layout and carrier types of the data-pump peripheral glue.
// Assumes one core clock; every address, length and field constant of the top module's logic lives here, though its checks repeat some as literals.
package dpglu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking
  localparam int OSC_KHZ = 40320;
  localparam int CODEC_DIV = 2;
  localparam int CODEC_KHZ = OSC_KHZ / CODEC_DIV;
  localparam int SYNTH_LOW_KHZ = 80640;
  localparam int SYNTH_HIGH_KHZ = 89740;

  ////////////////////////////////////////////////////////////////////////////
  // Shared RAM
  localparam int RAM_DEPTH = 16;
  localparam logic [15:0] RAM_FIRST = 16'h2000;
  localparam logic [15:0] RAM_LAST = 16'h200F;
  localparam logic [3:0] CTRL_ENTRY = 4'hE;
  localparam int SLEEP_BIT = 7;
  localparam logic [7:0] CTRL_KEEP_MASK = 8'h7F;
  localparam logic [7:0] RAM_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Core-side registers
  localparam logic [15:0] EYE_X_ADDR = 16'h3000;
  localparam logic [15:0] EYE_Y_ADDR = 16'h3001;
  localparam logic [15:0] SPC_ADDR = 16'h3002;
  localparam logic [15:0] NARROW_DATA_BASE = 16'h3004;
  localparam logic [15:0] WIDE_DATA_BASE = 16'h3008;
  localparam int NARROW_WORDS = 2;
  localparam int WIDE_WORDS = 4;

  // Serial port control fields
  localparam int SPC_NFR_OUT_BIT = 0;
  localparam int SPC_WFR_OUT_BIT = 1;
  localparam int SPC_WLEN_LSB = 2;
  localparam int SPC_WLEN_W = 6;
  localparam int SPC_BUSY_LSB = 8;
  localparam int SPC_DONE_LSB = 10;
  localparam logic [15:0] SPC_RESET = 16'h00FC;

  ////////////////////////////////////////////////////////////////////////////
  // Frame lengths
  localparam logic [6:0] NARROW_BITS = 7'h20;
  localparam logic [6:0] WIDE_MAX_BITS = 7'h40;
  localparam logic [4:0] EYE_BITS = 5'h10;

  typedef struct packed {
    logic frame_oe;
    logic frame_o;
    logic td;
  } dpglu_ser_out_t;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
  } dpglu_host_strb_t;

  typedef enum {EYE_IDLE, EYE_SHIFT} dpglu_eye_st_t;

endpackage

/* dpglu_top.sv */
// Peripheral glue around the data-pump core: clocks, two serial ports,
// shared RAM, interrupt staging, power-down latch and eye-pattern output.
// Assumes SCLK and all pins but the host strobes are synchronous to CORE_CLK, SCLK well slower.
`timescale 1ns/1ps

module dpglu_top
  import dpglu_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Clock control pins
  input wire logic PLL_SELECT_PIN,
  input wire logic TEST_MODE_PIN,
  output logic CODEC_REF_CLK,
  output logic SYNTH_HIGH_SEL,
  // Serial ports
  input wire logic SCLK,
  input wire logic NARROW_PORT_FRAME_I,
  output logic NARROW_PORT_FRAME_O,
  output logic NARROW_PORT_FRAME_OE,
  output logic NARROW_PORT_TX_DATA,
  input wire logic NARROW_PORT_RX_DATA,
  input wire logic WIDE_PORT_FRAME_I,
  output logic WIDE_PORT_FRAME_O,
  output logic WIDE_PORT_FRAME_OE,
  output logic WIDE_PORT_TX_DATA,
  input wire logic WIDE_PORT_RX_DATA,
  // Core data bus
  input wire logic [15:0] DSP_ADDR,
  input wire logic [15:0] DSP_WDATA,
  input wire logic DSP_WR,
  input wire logic DSP_RD,
  output logic [15:0] DSP_RDATA,
  // Host port
  input wire logic HOST_SELECT_N,
  input wire logic HOST_READ_STROBE_N,
  input wire logic HOST_WRITE_STROBE_N,
  input wire logic [3:0] HOST_ADDR,
  input wire logic [7:0] HOST_DATA_I,
  output logic [7:0] HOST_DATA_O,
  output logic HOST_DATA_OE,
  // Interrupts
  input wire logic [3:1] INTERRUPT_LINE_N,
  input wire logic INT_SRC0,
  output logic [3:0] CORE_IRQ,
  output logic [1:0] CORE_IRQ_TOP,
  // Power-down and eye pattern
  output logic SLEEP_REQUEST,
  output logic SCOPE_FRAME_OUT,
  output logic SCOPE_SERIAL_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Clocks
  logic codec_clk_r;
  logic synth_sel_r;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      codec_clk_r <= 1'b0;
    end else begin
      codec_clk_r <= ~codec_clk_r;
    end
  end

  // Test mode reserved: hold the low rate
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      synth_sel_r <= 1'b0;
    end else begin
      synth_sel_r <= PLL_SELECT_PIN & ~TEST_MODE_PIN;
    end
  end

  assign CODEC_REF_CLK = codec_clk_r;
  assign SYNTH_HIGH_SEL = synth_sel_r;

  ////////////////////////////////////////////////////////////////////////////
  // Core bus decode
  logic [15:0] spc_r;
  logic [15:0] dsp_rdata_r;
  logic [15:0] dsp_rd_nxt;
  logic [7:0] ram_r [RAM_DEPTH];
  logic [1:0] busy_r;
  logic [1:0] done_r;
  logic [63:0] rx_word_r [2];
  logic [63:0] tx_word_r [2];
  logic dsp_ram_hit;

  assign dsp_ram_hit = (DSP_ADDR >= RAM_FIRST) && (DSP_ADDR <= RAM_LAST);

  always_comb begin
    dsp_rd_nxt = 16'h0000;
    if (dsp_ram_hit) begin
      dsp_rd_nxt = {ram_r[DSP_ADDR[3:0]], 8'h00};
    end else if (DSP_ADDR == SPC_ADDR) begin
      dsp_rd_nxt = spc_r;
      dsp_rd_nxt[SPC_BUSY_LSB +: 2] = busy_r;
      dsp_rd_nxt[SPC_DONE_LSB +: 2] = done_r;
    end else if (DSP_ADDR[15:1] == NARROW_DATA_BASE[15:1]) begin
      dsp_rd_nxt = rx_word_r[0][{DSP_ADDR[0], 4'h0} +: 16];
    end else if (DSP_ADDR[15:2] == WIDE_DATA_BASE[15:2]) begin
      dsp_rd_nxt = rx_word_r[1][{DSP_ADDR[1:0], 4'h0} +: 16];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dsp_rdata_r <= 16'h0000;
    end else if (DSP_RD) begin
      dsp_rdata_r <= dsp_rd_nxt;
    end
  end

  assign DSP_RDATA = dsp_rdata_r;

  // Status bits are not stored here; they are overlaid on read
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      spc_r <= SPC_RESET;
    end else if (DSP_WR && DSP_ADDR == SPC_ADDR) begin
      spc_r <= {8'h00, DSP_WDATA[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host strobe synchronisers
  dpglu_host_strb_t hs1_r, hs2_r, hs3_r;
  logic [3:0] h_addr_r;
  logic [7:0] h_data_r;
  logic h_sel_r;
  logic h_commit;
  logic h_wr_act;
  logic h_rd_act;
  logic [7:0] host_out_r;
  logic host_oe_r;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      hs1_r <= '1;
      hs2_r <= '1;
      hs3_r <= '1;
    end else begin
      hs1_r <= {HOST_SELECT_N, HOST_READ_STROBE_N, HOST_WRITE_STROBE_N};
      hs2_r <= hs1_r;
      hs3_r <= hs2_r;
    end
  end

  assign h_wr_act = ~hs2_r.wr & ~hs2_r.cs;
  assign h_rd_act = ~hs2_r.rd & ~hs2_r.cs;
  // Commit on the trailing edge, when host data has settled
  assign h_commit = h_sel_r & hs2_r.wr & ~hs3_r.wr;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      h_sel_r <= 1'b0;
      h_addr_r <= 4'h0;
      h_data_r <= 8'h00;
    end else if (h_wr_act) begin
      h_sel_r <= 1'b1;
      h_addr_r <= HOST_ADDR;
      h_data_r <= HOST_DATA_I;
    end else if (h_commit) begin
      h_sel_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      host_out_r <= 8'h00;
      host_oe_r <= 1'b0;
    end else begin
      host_out_r <= ram_r[HOST_ADDR];
      host_oe_r <= h_rd_act;
    end
  end

  assign HOST_DATA_O = host_out_r;
  assign HOST_DATA_OE = host_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Shared RAM; the power-down bit is never stored, so it reads as zero
  logic sleep_r;

  // Host write lands last and wins a same-byte collision
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < RAM_DEPTH; i++) begin
        ram_r[i] <= RAM_RESET;
      end
    end else begin
      if (DSP_WR && dsp_ram_hit) begin
        ram_r[DSP_ADDR[3:0]] <= (DSP_ADDR[3:0] == CTRL_ENTRY) ?
          (DSP_WDATA[15:8] & CTRL_KEEP_MASK) : DSP_WDATA[15:8];
      end
      if (h_commit) begin
        ram_r[h_addr_r] <= (h_addr_r == CTRL_ENTRY) ?
          (h_data_r & CTRL_KEEP_MASK) : h_data_r;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sleep_r <= 1'b0;
    end else if (h_commit && h_addr_r == CTRL_ENTRY &&
                 h_data_r[SLEEP_BIT]) begin
      sleep_r <= 1'b1;
    end
  end

  assign SLEEP_REQUEST = sleep_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt staging
  logic [3:0] irq_r;
  logic [1:0] irq_top_r;
  logic [3:0] irq_nxt;

  function automatic logic [1:0] top_of(input logic [3:0] v);
    logic [1:0] t;
    t = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (v[i]) t = 2'(i);
    end
    return t;
  endfunction

  assign irq_nxt = {~INTERRUPT_LINE_N, INT_SRC0};

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      irq_r <= 4'h0;
      irq_top_r <= 2'h0;
    end else begin
      irq_r <= irq_nxt;
      irq_top_r <= top_of(irq_nxt);
    end
  end

  assign CORE_IRQ = irq_r;
  assign CORE_IRQ_TOP = irq_top_r;

  ////////////////////////////////////////////////////////////////////////////
  // Serial ports: both share SCLK, edges seen by one sample delay
  logic sclk_q_r;
  logic sclk_rise;
  logic sclk_fall;
  logic [1:0] fr_in;
  logic [1:0] rd_in;
  logic [1:0] fr_mode;
  logic [6:0] len [2];
  dpglu_ser_out_t ser_r [2];

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= SCLK;
    end
  end

  assign sclk_rise = SCLK & ~sclk_q_r;
  assign sclk_fall = ~SCLK & sclk_q_r;
  assign fr_in = {WIDE_PORT_FRAME_I, NARROW_PORT_FRAME_I};
  assign rd_in = {WIDE_PORT_RX_DATA, NARROW_PORT_RX_DATA};
  assign fr_mode = {spc_r[SPC_WFR_OUT_BIT], spc_r[SPC_NFR_OUT_BIT]};
  assign len[0] = NARROW_BITS;
  assign len[1] = {1'b0, spc_r[SPC_WLEN_LSB +: SPC_WLEN_W]} + 7'h01;

  for (genvar g = 0; g < 2; g++) begin : g_port
    localparam logic [15:0] BASE = (g == 0) ? NARROW_DATA_BASE :
                                              WIDE_DATA_BASE;
    localparam int NW = (g == 0) ? NARROW_WORDS : WIDE_WORDS;
    logic start;
    logic last;
    logic go;
    logic pend_r;
    logic [6:0] cnt_r;
    logic [63:0] tx_sh_r;
    logic [63:0] rx_sh_r;
    logic [63:0] aligned;

    // Word 0 is written last and launches a device-framed transfer
    assign go = DSP_WR && DSP_ADDR == BASE;
    assign start = sclk_rise & ~busy_r[g] &
                   (fr_mode[g] ? pend_r : ~fr_in[g]);
    assign last = sclk_fall & busy_r[g] & (cnt_r == len[g] - 7'h01);
    assign aligned = tx_word_r[g] << (WIDE_MAX_BITS - len[g]);

    // Words past the port's width stay zero
    for (genvar k = 0; k < WIDE_WORDS; k++) begin : g_word
      always_ff @(posedge CORE_CLK) begin
        if (RST) begin
          tx_word_r[g][16*k +: 16] <= 16'h0000;
        end else if (k < NW && DSP_WR && DSP_ADDR == BASE + 16'(k)) begin
          tx_word_r[g][16*k +: 16] <= DSP_WDATA;
        end
      end
    end

    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        pend_r <= 1'b0;
      end else begin
        pend_r <= go | (pend_r & ~start);
      end
    end

    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        busy_r[g] <= 1'b0;
        cnt_r <= 7'h00;
        tx_sh_r <= '0;
        rx_sh_r <= '0;
        rx_word_r[g] <= '0;
        ser_r[g].td <= 1'b0;
      end else if (start) begin
        busy_r[g] <= 1'b1;
        cnt_r <= 7'h00;
        ser_r[g].td <= aligned[63];
        tx_sh_r <= aligned << 1;
      end else if (busy_r[g]) begin
        if (sclk_rise) begin
          ser_r[g].td <= tx_sh_r[63];
          tx_sh_r <= tx_sh_r << 1;
        end
        if (sclk_fall) begin
          rx_sh_r <= {rx_sh_r[62:0], rd_in[g]};
          cnt_r <= cnt_r + 7'h01;
        end
        if (last) begin
          busy_r[g] <= 1'b0;
          rx_word_r[g] <= {rx_sh_r[62:0], rd_in[g]};
        end
      end
    end

    // Frame driven only while the port owns the line
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        ser_r[g].frame_o <= 1'b1;
        ser_r[g].frame_oe <= 1'b0;
      end else begin
        ser_r[g].frame_oe <= fr_mode[g];
        if (start && fr_mode[g]) begin
          ser_r[g].frame_o <= 1'b0;
        end else if (last || !fr_mode[g]) begin
          ser_r[g].frame_o <= 1'b1;
        end
      end
    end

    // Completion flag: a new completion beats a clear in the same cycle
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        done_r[g] <= 1'b0;
      end else begin
        done_r[g] <= last | (done_r[g] &
          ~(DSP_WR && DSP_ADDR == SPC_ADDR && DSP_WDATA[SPC_DONE_LSB + g]));
      end
    end
  end

  assign NARROW_PORT_FRAME_O = ser_r[0].frame_o;
  assign NARROW_PORT_FRAME_OE = ser_r[0].frame_oe;
  assign NARROW_PORT_TX_DATA = ser_r[0].td;
  assign WIDE_PORT_FRAME_O = ser_r[1].frame_o;
  assign WIDE_PORT_FRAME_OE = ser_r[1].frame_oe;
  assign WIDE_PORT_TX_DATA = ser_r[1].td;

  ////////////////////////////////////////////////////////////////////////////
  // Eye pattern: only the top bytes of X and Y fit in 16 periods
  dpglu_eye_st_t eye_st_r;
  logic [15:0] eye_x_r;
  logic [15:0] eye_y_r;
  logic [15:0] eye_sh_r;
  logic [15:0] eye_seq;
  logic [4:0] eye_cnt_r;
  logic eye_pend_r;
  logic scope_frame_out_r;
  logic scope_serial_out_r;
  logic eye_go;

  assign eye_go = DSP_WR && DSP_ADDR == EYE_Y_ADDR;
  assign eye_seq = {eye_x_r[15:8], eye_y_r[15:8]};

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      eye_x_r <= 16'h0000;
      eye_y_r <= 16'h0000;
    end else if (DSP_WR && DSP_ADDR == EYE_X_ADDR) begin
      eye_x_r <= DSP_WDATA;
    end else if (eye_go) begin
      eye_y_r <= DSP_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      eye_pend_r <= 1'b0;
    end else begin
      eye_pend_r <= eye_go |
        (eye_pend_r & ~(sclk_rise && eye_st_r == EYE_IDLE));
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      eye_st_r <= EYE_IDLE;
      scope_frame_out_r <= 1'b1;
      scope_serial_out_r <= 1'b0;
      eye_sh_r <= 16'h0000;
      eye_cnt_r <= 5'h00;
    end else if (sclk_rise) begin
      case (eye_st_r)
        EYE_IDLE: begin
          if (eye_pend_r) begin
            eye_st_r <= EYE_SHIFT;
            scope_frame_out_r <= 1'b0;
            scope_serial_out_r <= eye_seq[15];
            eye_sh_r <= eye_seq << 1;
            eye_cnt_r <= 5'h01;
          end
        end
        EYE_SHIFT: begin
          if (eye_cnt_r == EYE_BITS) begin
            eye_st_r <= EYE_IDLE;
            scope_frame_out_r <= 1'b1;
            scope_serial_out_r <= 1'b0;
          end else begin
            scope_serial_out_r <= eye_sh_r[15];
            eye_sh_r <= eye_sh_r << 1;
            eye_cnt_r <= eye_cnt_r + 5'h01;
          end
        end
        default: eye_st_r <= EYE_IDLE;
      endcase
    end
  end

  assign SCOPE_FRAME_OUT = scope_frame_out_r;
  assign SCOPE_SERIAL_OUT = scope_serial_out_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [4:0] eye_low_r;
  logic [6:0] nfall_r;
  logic [6:0] wfall_r;

  always_ff @(posedge CORE_CLK) begin
    if (RST || g_port[0].start) nfall_r <= 7'h00;
    else if (sclk_fall && busy_r[0]) nfall_r <= nfall_r + 7'h01;
    if (RST || g_port[1].start) wfall_r <= 7'h00;
    else if (sclk_fall && busy_r[1]) wfall_r <= wfall_r + 7'h01;
    if (RST || scope_frame_out_r) eye_low_r <= 5'h00;
    else if (sclk_rise) eye_low_r <= eye_low_r + 5'h01;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // Skip the edge after reset release: flops still hold reset values
  AST_CODEC_TOGGLE: assert property (!$past(RST) |->
    CODEC_REF_CLK != $past(CODEC_REF_CLK))
    else $error("codec clock did not toggle");
  AST_SYNTH_SEL: assert property (!$past(RST) |-> SYNTH_HIGH_SEL ==
    $past(PLL_SELECT_PIN && !TEST_MODE_PIN)) else $error("synth select");
  AST_NARROW_LEN: assert property ($fell(busy_r[0]) |-> nfall_r == 7'h20)
    else $error("narrow frame not 32 bits");
  AST_WIDE_LEN: assert property ($fell(busy_r[1]) |-> wfall_r == len[1])
    else $error("wide frame length wrong");
  AST_FRAME_OWN: assert property ($fell(NARROW_PORT_FRAME_O) |->
    NARROW_PORT_FRAME_OE) else $error("frame driven while input");
  AST_TX_MSB: assert property ($fell(NARROW_PORT_FRAME_O) |->
    NARROW_PORT_TX_DATA == $past(tx_word_r[0][31])) else $error("msb");
  AST_RAM_RW: assert property ((DSP_WR && dsp_ram_hit && !h_commit &&
    DSP_ADDR[3:0] != CTRL_ENTRY) ##1 (!DSP_WR && !h_commit) ##1
    (DSP_RD && DSP_ADDR == $past(DSP_ADDR, 2))
    |=> DSP_RDATA[15:8] == $past(DSP_WDATA[15:8], 3))
    else $error("shared ram byte lost");
  AST_RAM_LOW: assert property (DSP_RD && dsp_ram_hit |=>
    DSP_RDATA[7:0] == 8'h00) else $error("low byte not zero");
  AST_IRQ_TOP: assert property (CORE_IRQ[3] |-> CORE_IRQ_TOP == 2'h3)
    else $error("irq 3 not on top");
  AST_IRQ_PIN: assert property (!$past(RST) |-> CORE_IRQ[3:1] ==
    $past(~INTERRUPT_LINE_N)) else $error("irq pin not followed");
  AST_SLEEP_SET: assert property ((h_commit && h_addr_r == CTRL_ENTRY &&
    h_data_r[7]) |=> SLEEP_REQUEST) else $error("sleep not entered");
  AST_SLEEP_HOST: assert property (!SLEEP_REQUEST && !h_commit |=>
    !SLEEP_REQUEST) else $error("sleep set without host");
  AST_SLEEP_HOLD: assert property (SLEEP_REQUEST && !RST |=>
    SLEEP_REQUEST) else $error("sleep left without reset");
  AST_EYE_LOW16: assert property ($rose(SCOPE_FRAME_OUT) |->
    eye_low_r == 5'h10) else $error("eye frame not 16 periods");
  AST_EYE_FIRST: assert property ($fell(SCOPE_FRAME_OUT) |->
    SCOPE_SERIAL_OUT == $past(eye_x_r[15])) else $error("eye first bit");
  AST_HOST_SYNC: assert property (h_commit |->
    $past(HOST_WRITE_STROBE_N, 2)) else $error("unsynchronised commit");

  COV_NARROW: cover property ($fell(busy_r[0]));
  COV_WIDE: cover property ($fell(busy_r[1]));
  COV_EYE: cover property ($rose(SCOPE_FRAME_OUT));
  COV_HOST_WR: cover property (h_commit);

endmodule

/* dpglu_codec_model.sv */
// Converter-side serial port model, one instance per port.
// Assumes the bench makes SCLK and resolves the frame line.
`timescale 1ns/1ps

module dpglu_codec_model (
  // Serial line
  input wire logic sclk,
  input wire logic frame_line,
  input wire logic td,
  // Bench control
  input wire logic go,
  input wire logic drive_frame,
  input wire logic [6:0] len,
  input wire logic [63:0] pat,
  // Pins and results
  output logic frame_i,
  output logic rd,
  output logic [63:0] cap,
  output int nbits
);
  int k;
  initial begin
    frame_i = 1'b1;
    rd = 1'b0;
    cap = 64'h0;
    nbits = 0;
    k = 0;
  end
  always @(posedge go) begin
    k = len;
    nbits = 0;
    if (drive_frame)
      frame_i = 1'b0;
  end
  // Idle bit flips so stale data never looks valid
  always @(posedge sclk) begin
    if (k > 0) begin
      rd = pat[k-1];
      k = k - 1;
    end else
      rd = ~rd;
  end
  always @(negedge sclk) begin
    if (!frame_line) begin
      cap = {cap[62:0], td};
      nbits = nbits + 1;
      if (nbits == len)
        frame_i = 1'b1;
    end
  end
endmodule

/* testbench.sv */
// Bench for the glue top: core bus, host port, serial, eye, irqs.
// Assumes the package and the codec model are compiled first.
`timescale 1ns/1ps

module testbench;
  import dpglu_pkg::*;
  logic clk, rst, pll_sel, test_md, sclk, sclk_run, go, src0;
  logic dsp_wr, dsp_rd, cs_n, rd_n, wr_n, mcu_oe, hdoe, sleep;
  logic ref_clk, synth_hi, nfo, nfoe, ntd, wfo, wfoe, wtd;
  logic scope_frame_out, scope_serial_out, nfi, nrd, wfi, wrd;
  logic [15:0] dsp_addr, dsp_wdata, rdata, eye_cap;
  logic [7:0] mcu_d, hdo;
  logic [3:0] haddr, cirq;
  logic [3:1] irq_n;
  logic [1:0] ctop, div;
  logic [63:0] ncap, wcap;
  int nn, nw, eye_n, fails, n_checks;
  wire [7:0] host_w = hdoe ? hdo : (mcu_oe ? mcu_d : ~hdo);

  dpglu_top uut (.CORE_CLK(clk), .RST(rst), .PLL_SELECT_PIN(pll_sel),
    .TEST_MODE_PIN(test_md), .CODEC_REF_CLK(ref_clk),
    .SYNTH_HIGH_SEL(synth_hi), .SCLK(sclk), .NARROW_PORT_FRAME_I(nfi),
    .NARROW_PORT_FRAME_O(nfo), .NARROW_PORT_FRAME_OE(nfoe),
    .NARROW_PORT_TX_DATA(ntd), .NARROW_PORT_RX_DATA(nrd),
    .WIDE_PORT_FRAME_I(wfi), .WIDE_PORT_FRAME_O(wfo),
    .WIDE_PORT_FRAME_OE(wfoe), .WIDE_PORT_TX_DATA(wtd),
    .WIDE_PORT_RX_DATA(wrd), .DSP_ADDR(dsp_addr), .DSP_WDATA(dsp_wdata),
    .DSP_WR(dsp_wr), .DSP_RD(dsp_rd), .DSP_RDATA(rdata),
    .HOST_SELECT_N(cs_n), .HOST_READ_STROBE_N(rd_n),
    .HOST_WRITE_STROBE_N(wr_n), .HOST_ADDR(haddr), .HOST_DATA_I(host_w),
    .HOST_DATA_O(hdo), .HOST_DATA_OE(hdoe), .INTERRUPT_LINE_N(irq_n),
    .INT_SRC0(src0), .CORE_IRQ(cirq), .CORE_IRQ_TOP(ctop),
    .SLEEP_REQUEST(sleep), .SCOPE_FRAME_OUT(scope_frame_out),
    .SCOPE_SERIAL_OUT(scope_serial_out));
  dpglu_codec_model nmod (.sclk(sclk), .frame_line(nfoe ? nfo : nfi),
    .td(ntd), .go(go), .drive_frame(1'b0), .len(NARROW_BITS),
    .pat(64'hCAFEF00D), .frame_i(nfi), .rd(nrd), .cap(ncap), .nbits(nn));
  dpglu_codec_model wmod (.sclk(sclk), .frame_line(wfoe ? wfo : wfi),
    .td(wtd), .go(go), .drive_frame(1'b1), .len(WIDE_MAX_BITS),
    .pat(64'hFEDCBA9876543210), .frame_i(wfi), .rd(wrd), .cap(wcap),
    .nbits(nw));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, rst, pll_sel, test_md, sclk, sclk_run, go, src0} = 8'h40;
    {dsp_wr, dsp_rd, cs_n, rd_n, wr_n, mcu_oe} = 6'h0E;
    {dsp_addr, dsp_wdata, mcu_d, haddr, irq_n, div} = 49'h1C;
    {eye_n, eye_cap, fails, n_checks} = 0;
    forever #2.5 clk = ~clk;
  end
  // Keeps running until low so a restart never begins on a fall
  always @(posedge clk)
    if (sclk_run || sclk) begin
      div <= div + 2'h1;
      if (div == 2'h3)
        sclk <= ~sclk;
    end
  always @(negedge sclk)
    if (!scope_frame_out) begin
      eye_cap <= {eye_cap[14:0], scope_serial_out};
      eye_n <= eye_n + 1;
    end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic dwr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk) {dsp_addr, dsp_wdata, dsp_wr} <= {a, d, 1'b1};
    @(posedge clk) dsp_wr <= 1'b0;
  endtask
  task automatic drd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk) {dsp_addr, dsp_rd} <= {a, 1'b1};
    @(posedge clk) dsp_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic hwr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {cs_n, wr_n, mcu_oe, haddr, mcu_d} <= {3'b001, a, d};
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    {cs_n, mcu_oe} <= 2'b10;
    repeat (4) @(posedge clk);
  endtask
  task automatic hrd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) {cs_n, rd_n, haddr} <= {2'b00, a};
    repeat (6) @(posedge clk);
    #1 chk({hdoe, host_w}, {1'b1, exp});
    @(posedge clk) {cs_n, rd_n} <= 2'b11;
    repeat (5) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run needs about 1000 cycles
  initial begin
    #100000 fails++;
    close_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic a;
    int t;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1 a = ref_clk;
    @(posedge clk) #1 chk(ref_clk, !a);
    chk({sleep, scope_frame_out, nfoe, wfoe}, 4'h4);
    drd(SPC_ADDR, SPC_RESET);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {test_md, pll_sel} <= i[1:0];
      repeat (3) @(posedge clk);
      #1 chk(synth_hi, i[0] & ~i[1]);
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge clk) {irq_n, src0} <= {~i[3:1], i[0]};
      repeat (3) @(posedge clk);
      t = 0;
      for (int j = 0; j < 4; j++)
        if (i[j])
          t = j;
      #1 chk({cirq, ctop}, {i[3:0], t[1:0]});
    end
    dwr(RAM_FIRST, 16'h5AFF);
    drd(RAM_FIRST, 16'h5A00);
    dwr(RAM_LAST, 16'hC3FF);
    hrd(4'hF, 8'hC3);
    hwr(4'h5, 8'hA5);
    drd(16'h2005, 16'hA500);
    drd(16'h2010, 16'h0000);
    dwr(EYE_X_ADDR, 16'hA5FF);
    dwr(EYE_Y_ADDR, 16'h3C00);
    drd(EYE_X_ADDR, 16'h0000);
    @(posedge clk) sclk_run <= 1'b1;
    for (int i = 0; i < 400 && (eye_n < 16 || !scope_frame_out); i++)
      @(posedge clk);
    repeat (40) @(posedge clk) sclk_run <= 1'b0;
    chk({eye_n, scope_frame_out}, {32'd16, 1'b1});
    chk(eye_cap, 16'hA53C);
    dwr(SPC_ADDR, 16'h00FD);
    dwr(NARROW_DATA_BASE + 16'h1, 16'h1234);
    dwr(NARROW_DATA_BASE, 16'h5678);
    for (int i = 3; i >= 0; i--)
      dwr(WIDE_DATA_BASE + 16'(i), 16'h0123 << 0 ^ 16'(i * 16'h4444));
    chk({nfoe, wfoe}, 2'b10);
    @(posedge clk) {go, sclk_run} <= 2'b11;
    for (int i = 0; i < 3000 && !(nn == 32 && nw == 64); i++)
      @(posedge clk);
    repeat (20) @(posedge clk) sclk_run <= 1'b0;
    chk({nn, nw}, {32'd32, 32'd64});
    chk(ncap[31:0], 32'h12345678);
    chk(wcap, 64'hCDEF89AB45670123);
    drd(SPC_ADDR, 16'h0CFD);
    drd(NARROW_DATA_BASE + 16'h1, 16'hCAFE);
    drd(NARROW_DATA_BASE, 16'hF00D);
    for (int i = 0; i < 4; i++)
      drd(WIDE_DATA_BASE + 16'(i), 16'h3210 + 16'(i * 16'h4444));
    dwr(SPC_ADDR, 16'h0CFD);
    drd(SPC_ADDR, 16'h00FD);
    dwr(16'h200E, 16'hFF00);
    drd(16'h200E, 16'h7F00);
    hwr(CTRL_ENTRY, 8'h80);
    chk(sleep, 1'b1);
    hwr(CTRL_ENTRY, 8'h00);
    chk(sleep, 1'b1);
    hrd(CTRL_ENTRY, 8'h00);
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1 chk(sleep, 1'b0);
    close_out;
  end
endmodule
